// ==== rtl/seg_arith_pkg.sv ====
package seg_arith_pkg;

  // ************************************************************
  // Opcode patterns
  // ************************************************************
  localparam logic [7:0] PFX_CODE     = 8'h2E;
  localparam logic [7:0] PFX_STACK    = 8'h36;
  localparam logic [7:0] PFX_DATA     = 8'h3E;
  localparam logic [7:0] PFX_EXTRA    = 8'h26;
  localparam logic [5:0] OPC_ADD_RM   = 6'h00;
  localparam logic [5:0] OPC_ADC_RM   = 6'h04;
  localparam logic [5:0] OPC_SUB_RM   = 6'h0A;
  localparam logic [5:0] OPC_SBB_RM   = 6'h06;
  localparam logic [5:0] OPC_IMM_GRP  = 6'h20;
  localparam logic [6:0] OPC_ADC_ACC  = 7'h0A;
  localparam logic [6:0] OPC_SUB_ACC  = 7'h16;
  localparam logic [6:0] OPC_SBB_ACC  = 7'h0E;
  localparam logic [6:0] OPC_NEG_GRP  = 7'h7B;
  localparam logic [7:0] OPC_ASCII_AA = 8'h37;
  localparam logic [7:0] OPC_DEC_AA   = 8'h27;
  localparam logic [7:0] OPC_ASCII_AS = 8'h3F;
  localparam logic [7:0] OPC_DEC_AS   = 8'h2F;
  localparam logic [2:0] MID_ADC      = 3'h2;
  localparam logic [2:0] MID_SUB      = 3'h5;
  localparam logic [2:0] MID_SBB      = 3'h3;
  localparam logic [2:0] MID_NEG      = 3'h3;
  localparam logic [1:0] MOD_REG      = 2'h3;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_W   = 0;
  localparam int BIT_D   = 1;
  localparam int BIT_S   = 1;
  localparam int MID_LSB = 3;
  localparam int MOD_LSB = 6;

  // ************************************************************
  // Clock counts
  // ************************************************************
  localparam logic [4:0] CLK_PREFIX = 5'h02;
  localparam logic [4:0] CLK_RM_REG = 5'h03;
  localparam logic [4:0] CLK_RM_MEM = 5'h0A;
  localparam logic [4:0] CLK_IM_REG = 5'h04;
  localparam logic [4:0] CLK_IM_MEM = 5'h10;
  localparam logic [4:0] CLK_ACC_B  = 5'h03;
  localparam logic [4:0] CLK_ACC_W  = 5'h04;
  localparam logic [4:0] CLK_AAA    = 5'h08;
  localparam logic [4:0] CLK_DAA    = 5'h04;
  localparam logic [4:0] CLK_AAS    = 5'h07;
  localparam logic [4:0] CLK_DAS    = 5'h04;

  // ************************************************************
  // Operations and segments
  // ************************************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ADD = 4'h1, OP_ADC = 4'h2, OP_SUB = 4'h3,
    OP_SBB  = 4'h4, OP_NEG = 4'h5, OP_AAA = 4'h6, OP_DAA = 4'h7,
    OP_AAS  = 4'h8, OP_DAS = 4'h9
  } op_t;

  typedef enum logic [2:0] {
    SEG_DEFAULT = 3'h0, SEG_CODE = 3'h1, SEG_STACK = 3'h2,
    SEG_DATA    = 3'h3, SEG_EXTRA = 3'h4
  } seg_t;

  localparam logic [15:0] SIGN_FILL = 16'hFF00;

endpackage

// ==== rtl/imm_extend.sv ====
module imm_extend (
  input  wire logic [7:0]  immLow,
  input  wire logic [7:0]  immHigh,
  input  wire logic        wordOp,
  input  wire logic        signExt,
  output logic      [15:0] immValue
);

  always_comb begin
    if (!wordOp) begin
      immValue = {8'h00, immLow};
    end else if (signExt) begin
      immValue = immLow[7] ? (seg_arith_pkg::SIGN_FILL | {8'h00, immLow}) : {8'h00, immLow};
    end else begin
      immValue = {immHigh, immLow};
    end
  end

endmodule

// ==== rtl/segment_prefix_arith_decoder.sv ====
module segment_prefix_arith_decoder (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        byteValid,
  input  wire logic [7:0]                  byteData,
  output logic                             byteTaken,
  output logic                             decValid,
  output seg_arith_pkg::op_t               decOp,
  output seg_arith_pkg::seg_t              decSeg,
  output logic                             decWord,
  output logic                             decRegDest,
  output logic                             decMemOp,
  output logic                             decUseAcc,
  output logic [2:0]                       decRegField,
  output logic [2:0]                       decRmField,
  output logic [1:0]                       decModField,
  output logic [15:0]                      decImm,
  output logic [4:0]                       decClocks,
  output logic                             decIllegal
);

  // ************************************************************
  // Collection state machine
  // ************************************************************
  typedef enum logic [4:0] {
    ST_OPC  = 5'b00001,
    ST_MODR = 5'b00010,
    ST_IMML = 5'b00100,
    ST_IMMH = 5'b01000,
    ST_DONE = 5'b10000
  } state_t;

  state_t              state_q, state_d;
  logic [7:0]          opc_q, opc_d;
  logic [7:0]          modrm_q, modrm_d;
  logic [7:0]          immL_q, immL_d;
  logic [7:0]          immH_q, immH_d;
  seg_arith_pkg::seg_t seg_q, seg_d;
  seg_arith_pkg::op_t  op_q, op_d;
  logic                acc_q, acc_d;
  logic                imm_q, imm_d;
  logic                ill_q, ill_d;
  logic                valid_q, valid_d;
  logic [4:0]          clk_q, clk_d;
  logic [15:0]         imm16;
  logic                w, sx, isMem;

  assign w     = opc_q[seg_arith_pkg::BIT_W];
  assign sx    = opc_q[seg_arith_pkg::BIT_S] & (opc_q[7:2] == seg_arith_pkg::OPC_IMM_GRP);
  assign isMem = modrm_q[7:6] != seg_arith_pkg::MOD_REG;

  imm_extend i_imm_extend (
    .immLow   (immL_q),
    .immHigh  (immH_q),
    .wordOp   (w),
    .signExt  (sx),
    .immValue (imm16)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [7:0] b;
    logic [2:0] mid;
    b       = byteData;
    mid     = byteData[5:3];
    state_d = state_q;
    opc_d   = opc_q;
    modrm_d = modrm_q;
    immL_d  = immL_q;
    immH_d  = immH_q;
    // Override lasts only for the instruction after the prefix
    seg_d   = (valid_q && (op_q != seg_arith_pkg::OP_NONE || ill_q)) ? seg_arith_pkg::SEG_DEFAULT : seg_q;
    op_d    = op_q;
    acc_d   = acc_q;
    imm_d   = imm_q;
    ill_d   = ill_q;
    valid_d = 1'b0;
    clk_d   = clk_q;
    case (state_q)
      ST_OPC: begin
        if (byteValid) begin
          opc_d   = b;
          acc_d   = 1'b0;
          imm_d   = 1'b0;
          ill_d   = 1'b0;
          modrm_d = 8'h00;
          immL_d  = 8'h00;
          immH_d  = 8'h00;
          state_d = ST_DONE;
          clk_d   = seg_arith_pkg::CLK_RM_REG;
          if      (b == seg_arith_pkg::PFX_CODE)  begin seg_d = seg_arith_pkg::SEG_CODE;  op_d = seg_arith_pkg::OP_NONE; end
          else if (b == seg_arith_pkg::PFX_STACK) begin seg_d = seg_arith_pkg::SEG_STACK; op_d = seg_arith_pkg::OP_NONE; end
          else if (b == seg_arith_pkg::PFX_DATA)  begin seg_d = seg_arith_pkg::SEG_DATA;  op_d = seg_arith_pkg::OP_NONE; end
          else if (b == seg_arith_pkg::PFX_EXTRA) begin seg_d = seg_arith_pkg::SEG_EXTRA; op_d = seg_arith_pkg::OP_NONE; end
          else if (b == seg_arith_pkg::OPC_ASCII_AA) begin op_d = seg_arith_pkg::OP_AAA; clk_d = seg_arith_pkg::CLK_AAA; end
          else if (b == seg_arith_pkg::OPC_DEC_AA)   begin op_d = seg_arith_pkg::OP_DAA; clk_d = seg_arith_pkg::CLK_DAA; end
          else if (b == seg_arith_pkg::OPC_ASCII_AS) begin op_d = seg_arith_pkg::OP_AAS; clk_d = seg_arith_pkg::CLK_AAS; end
          else if (b == seg_arith_pkg::OPC_DEC_AS)   begin op_d = seg_arith_pkg::OP_DAS; clk_d = seg_arith_pkg::CLK_DAS; end
          else if (b[7:2] == seg_arith_pkg::OPC_ADD_RM) begin op_d = seg_arith_pkg::OP_ADD; state_d = ST_MODR; end
          else if (b[7:2] == seg_arith_pkg::OPC_ADC_RM) begin op_d = seg_arith_pkg::OP_ADC; state_d = ST_MODR; end
          else if (b[7:2] == seg_arith_pkg::OPC_SUB_RM) begin op_d = seg_arith_pkg::OP_SUB; state_d = ST_MODR; end
          else if (b[7:2] == seg_arith_pkg::OPC_SBB_RM) begin op_d = seg_arith_pkg::OP_SBB; state_d = ST_MODR; end
          else if (b[7:2] == seg_arith_pkg::OPC_IMM_GRP || b[7:1] == seg_arith_pkg::OPC_NEG_GRP) begin
            state_d = ST_MODR;
          end
          else if (b[7:1] == seg_arith_pkg::OPC_ADC_ACC) begin op_d = seg_arith_pkg::OP_ADC; acc_d = 1'b1; imm_d = 1'b1; state_d = ST_IMML; end
          else if (b[7:1] == seg_arith_pkg::OPC_SUB_ACC) begin op_d = seg_arith_pkg::OP_SUB; acc_d = 1'b1; imm_d = 1'b1; state_d = ST_IMML; end
          else if (b[7:1] == seg_arith_pkg::OPC_SBB_ACC) begin op_d = seg_arith_pkg::OP_SBB; acc_d = 1'b1; imm_d = 1'b1; state_d = ST_IMML; end
          else begin op_d = seg_arith_pkg::OP_NONE; ill_d = 1'b1; end
          if (acc_d) begin
            clk_d = b[seg_arith_pkg::BIT_W] ? seg_arith_pkg::CLK_ACC_W : seg_arith_pkg::CLK_ACC_B;
          end
        end
      end
      ST_MODR: begin
        if (byteValid) begin
          modrm_d = b;
          state_d = ST_DONE;
          if (opc_q[7:2] == seg_arith_pkg::OPC_IMM_GRP) begin
            imm_d   = 1'b1;
            state_d = ST_IMML;
            clk_d   = (b[7:6] != seg_arith_pkg::MOD_REG) ? seg_arith_pkg::CLK_IM_MEM : seg_arith_pkg::CLK_IM_REG;
            if      (mid == seg_arith_pkg::MID_ADC) op_d = seg_arith_pkg::OP_ADC;
            else if (mid == seg_arith_pkg::MID_SUB) op_d = seg_arith_pkg::OP_SUB;
            else if (mid == seg_arith_pkg::MID_SBB) op_d = seg_arith_pkg::OP_SBB;
            else begin op_d = seg_arith_pkg::OP_NONE; ill_d = 1'b1; imm_d = 1'b0; state_d = ST_DONE; end
          end else begin
            clk_d = (b[7:6] != seg_arith_pkg::MOD_REG) ? seg_arith_pkg::CLK_RM_MEM : seg_arith_pkg::CLK_RM_REG;
            if (opc_q[7:1] == seg_arith_pkg::OPC_NEG_GRP) begin
              if (mid == seg_arith_pkg::MID_NEG) op_d = seg_arith_pkg::OP_NEG;
              else begin op_d = seg_arith_pkg::OP_NONE; ill_d = 1'b1; end
            end
          end
        end
      end
      ST_IMML: begin
        if (byteValid) begin
          immL_d  = b;
          state_d = (w && !sx) ? ST_IMMH : ST_DONE;
        end
      end
      ST_IMMH: begin
        if (byteValid) begin
          immH_d  = b;
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        valid_d = 1'b1;
        state_d = ST_OPC;
        if (op_q == seg_arith_pkg::OP_NONE && !ill_q) begin
          clk_d = seg_arith_pkg::CLK_PREFIX;
        end
      end
      default: state_d = ST_OPC;
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OPC;
      opc_q   <= 8'h00;
      modrm_q <= 8'h00;
      immL_q  <= 8'h00;
      immH_q  <= 8'h00;
      seg_q   <= seg_arith_pkg::SEG_DEFAULT;
      op_q    <= seg_arith_pkg::OP_NONE;
      acc_q   <= 1'b0;
      imm_q   <= 1'b0;
      ill_q   <= 1'b0;
      valid_q <= 1'b0;
      clk_q   <= 5'h00;
    end else begin
      state_q <= state_d;
      opc_q   <= opc_d;
      modrm_q <= modrm_d;
      immL_q  <= immL_d;
      immH_q  <= immH_d;
      seg_q   <= seg_d;
      op_q    <= op_d;
      acc_q   <= acc_d;
      imm_q   <= imm_d;
      ill_q   <= ill_d;
      valid_q <= valid_d;
      clk_q   <= clk_d;
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  logic        outV_q;
  logic [15:0] outImm_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      byteTaken   <= 1'b0;
      outV_q      <= 1'b0;
      decOp       <= seg_arith_pkg::OP_NONE;
      decSeg      <= seg_arith_pkg::SEG_DEFAULT;
      decWord     <= 1'b0;
      decRegDest  <= 1'b0;
      decMemOp    <= 1'b0;
      decUseAcc   <= 1'b0;
      decRegField <= 3'h0;
      decRmField  <= 3'h0;
      decModField <= 2'h0;
      outImm_q    <= 16'h0000;
      decClocks   <= 5'h00;
      decIllegal  <= 1'b0;
    end else begin
      byteTaken <= byteValid && (state_q != ST_DONE);
      outV_q    <= valid_d;
      if (valid_d) begin
        decOp       <= op_q;
        decSeg      <= seg_q;
        decWord     <= w;
        decRegDest  <= opc_q[seg_arith_pkg::BIT_D] & ~opc_q[7];
        decMemOp    <= isMem & ~acc_q & (op_q > seg_arith_pkg::OP_NONE) & (op_q < seg_arith_pkg::OP_AAA);
        decUseAcc   <= acc_q;
        decRegField <= modrm_q[5:3];
        decRmField  <= modrm_q[2:0];
        decModField <= modrm_q[7:6];
        outImm_q    <= imm_q ? imm16 : 16'h0000;
        decClocks   <= clk_d;
        decIllegal  <= ill_q;
      end
    end
  end
  assign decValid = outV_q;
  assign decImm   = outImm_q;

  a_prefix_clocks: assert property (@(posedge mclk) disable iff (!rst_n)
    decValid && decOp == seg_arith_pkg::OP_NONE && !decIllegal
    |-> decClocks == seg_arith_pkg::CLK_PREFIX && decSeg != seg_arith_pkg::SEG_DEFAULT)
    else $error("prefix timing wrong");
  a_adjust_clocks: assert property (@(posedge mclk) disable iff (!rst_n)
    decValid && decOp == seg_arith_pkg::OP_AAA |-> decClocks == seg_arith_pkg::CLK_AAA)
    else $error("ascii add adjust timing wrong");
  a_decimal_add_clocks: assert property (@(posedge mclk) disable iff (!rst_n)
    decValid && decOp == seg_arith_pkg::OP_DAA |-> decClocks == seg_arith_pkg::CLK_DAA)
    else $error("decimal add adjust timing wrong");
  a_ascii_sub_clocks: assert property (@(posedge mclk) disable iff (!rst_n)
    decValid && decOp == seg_arith_pkg::OP_AAS |-> decClocks == seg_arith_pkg::CLK_AAS)
    else $error("ascii subtract adjust timing wrong");
  a_decimal_sub_clocks: assert property (@(posedge mclk) disable iff (!rst_n)
    decValid && decOp == seg_arith_pkg::OP_DAS |-> decClocks == seg_arith_pkg::CLK_DAS)
    else $error("decimal subtract adjust timing wrong");
  a_add_clocks: assert property (@(posedge mclk) disable iff (!rst_n)
    decValid && decOp == seg_arith_pkg::OP_ADD
    |-> decClocks == (decMemOp ? seg_arith_pkg::CLK_RM_MEM : seg_arith_pkg::CLK_RM_REG))
    else $error("add timing wrong");
  a_negate_clocks: assert property (@(posedge mclk) disable iff (!rst_n)
    decValid && decOp == seg_arith_pkg::OP_NEG
    |-> decClocks == (decMemOp ? seg_arith_pkg::CLK_RM_MEM : seg_arith_pkg::CLK_RM_REG))
    else $error("negate timing wrong");

endmodule

// ==== verif/prefetch_queue_model.sv ====
module prefetch_queue_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       byteTaken,
  output logic            byteValid,
  output logic      [7:0] byteData
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Byte source: one offer at a time, stalls, redelivery on refusal
  // ************************************************************
  logic [7:0] pend[$];
  logic [1:0] state;
  int         sent;
  int         stall;

  // Released data toggles so a stale byte never looks valid
  always @(posedge mclk) begin
    if (rst_n !== 1'b1) begin
      byteValid <= 1'b0;
      byteData  <= 8'h00;
      state     <= 2'h0;
      sent      <= 0;
      stall     <= 0;
    end else begin
      case (state)
        2'h0: begin
          if (pend.size() != 0 && stall == 0) begin
            byteValid <= 1'b1;
            byteData  <= pend[0];
            state     <= 2'h1;
          end else begin
            byteData <= ~byteData;
            if (stall != 0) stall <= stall - 1;
          end
        end
        2'h1: begin
          byteValid <= 1'b0;
          byteData  <= ~byteData;
          state     <= 2'h2;
        end
        default: begin
          byteData <= ~byteData;
          if (byteTaken === 1'b1) begin
            void'(pend.pop_front());
            sent  <= sent + 1;
            stall <= (sent % 3 == 2) ? 2 : 0;
          end
          state <= 2'h0;
        end
      endcase
    end
  end
endmodule

// ==== verif/test_segment_prefix_arith_decoder.sv ====
module test_segment_prefix_arith_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    seg_arith_pkg::op_t  op;
    seg_arith_pkg::seg_t seg;
    logic [4:0]          clk;
    logic [2:0]          kind;
    logic                w;
    logic                d;
    logic [7:0]          modrm;
    logic [15:0]         imm;
    logic                ill;
  } exp_t;

  localparam logic [7:0]          RM_BASE [4] = '{8'h00, 8'h10, 8'h28, 8'h18};
  localparam logic [7:0]          ACC_BASE [4] = '{8'h00, 8'h14, 8'h2C, 8'h1C};
  localparam logic [2:0]          IMM_MID [4] = '{3'h0, 3'h2, 3'h5, 3'h3};
  localparam seg_arith_pkg::op_t  OPS [4] = '{seg_arith_pkg::OP_ADD, seg_arith_pkg::OP_ADC,
                                               seg_arith_pkg::OP_SUB, seg_arith_pkg::OP_SBB};
  localparam logic [7:0]          PFX [4] = '{8'h2E, 8'h36, 8'h3E, 8'h26};
  localparam seg_arith_pkg::seg_t SEGS [4] = '{seg_arith_pkg::SEG_CODE, seg_arith_pkg::SEG_STACK,
                                               seg_arith_pkg::SEG_DATA, seg_arith_pkg::SEG_EXTRA};

  logic                mclk;
  logic                rst_n;
  logic                byteValid;
  logic [7:0]          byteData;
  logic                byteTaken;
  logic                decValid;
  seg_arith_pkg::op_t  decOp;
  seg_arith_pkg::seg_t decSeg;
  logic                decWord;
  logic                decRegDest;
  logic                decMemOp;
  logic                decUseAcc;
  logic [2:0]          decRegField;
  logic [2:0]          decRmField;
  logic [1:0]          decModField;
  logic [15:0]         decImm;
  logic [4:0]          decClocks;
  logic                decIllegal;
  exp_t                expQ[$];
  exp_t                got;
  seg_arith_pkg::seg_t curSeg;
  logic [7:0]          m;
  logic [15:0]         v;
  int                  num_errors;
  int                  num_checks;
  int                  seed;

  segment_prefix_arith_decoder i_segment_prefix_arith_decoder (
    .mclk(mclk), .rst_n(rst_n), .byteValid(byteValid), .byteData(byteData), .byteTaken(byteTaken),
    .decValid(decValid), .decOp(decOp), .decSeg(decSeg), .decWord(decWord), .decRegDest(decRegDest),
    .decMemOp(decMemOp), .decUseAcc(decUseAcc), .decRegField(decRegField), .decRmField(decRmField),
    .decModField(decModField), .decImm(decImm), .decClocks(decClocks), .decIllegal(decIllegal)
  );

  prefetch_queue_model i_prefetch_queue_model (
    .mclk(mclk), .rst_n(rst_n), .byteTaken(byteTaken), .byteValid(byteValid), .byteData(byteData)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    num_checks++;
    if (seen !== expv) begin
      num_errors++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ************************************************************
  // Stimulus helpers
  // ************************************************************
  task automatic issue(input logic [7:0] opc, input seg_arith_pkg::op_t op, input logic [4:0] clk,
                       input logic [2:0] kind, input logic [7:0] mr, input logic [15:0] imm);
    exp_t e;
    e = '{op, curSeg, clk, kind, opc[0], opc[1], mr, imm, op == seg_arith_pkg::OP_NONE && clk == 5'h00};
    i_prefetch_queue_model.pend.push_back(opc);
    if (kind inside {3'h1, 3'h2, 3'h4}) i_prefetch_queue_model.pend.push_back(mr);
    if (kind inside {3'h2, 3'h3}) i_prefetch_queue_model.pend.push_back(imm[7:0]);
    if ((kind == 3'h2 && opc[1:0] == 2'b01) || (kind == 3'h3 && opc[0])) i_prefetch_queue_model.pend.push_back(imm[15:8]);
    expQ.push_back(e);
    curSeg = seg_arith_pkg::SEG_DEFAULT;
  endtask

  // Memory forms avoid the direct-address encoding, which would carry a displacement
  function automatic logic [7:0] rnd_modrm(input logic [2:0] mid);
    logic [7:0] r;
    r = {($random(seed) & 1) ? 2'b11 : 2'b00, mid, 3'($random(seed))};
    if (r[7:6] == 2'b00 && r[2:0] == 3'h6) r[2:0] = 3'h7;
    return r;
  endfunction

  function automatic logic [4:0] rc(input logic [7:0] mr, input logic [4:0] rg, input logic [4:0] mem);
    return (mr[7:6] == 2'b11) ? rg : mem;
  endfunction

  // ************************************************************
  // Result monitor
  // ************************************************************
  always @(posedge mclk) begin
    if (rst_n === 1'b1 && decValid === 1'b1) begin
      if (expQ.size() == 0) begin
        check(16'h0001, 16'h0000, "unexpected decode");
      end else begin
        got = expQ.pop_front();
        check(16'(decOp), 16'(got.op), "operation");
        check(16'(decSeg), 16'(got.seg), "segment");
        check(16'(decIllegal), 16'(got.ill), "illegal flag");
        if (!got.ill) check(16'(decClocks), 16'(got.clk), "clocks");
        if (got.kind != 3'h0) check(16'(decWord), 16'(got.w), "width");
        if (got.kind != 3'h0) check(16'(decUseAcc), 16'(got.kind == 3'h3), "accumulator");
        if (got.kind inside {3'h1, 3'h2, 3'h4}) begin
          check(16'({decModField, decRmField}), 16'({got.modrm[7:6], got.modrm[2:0]}), "operand");
          check(16'(decMemOp), 16'(got.modrm[7:6] != 2'b11), "memory operand");
        end
        if (got.kind == 3'h1) check(16'({decRegDest, decRegField}), 16'({got.d, got.modrm[5:3]}), "dir");
        if (got.kind inside {3'h2, 3'h3}) check(decImm, got.w ? got.imm : {8'h00, got.imm[7:0]}, "immediate");
      end
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    seed       = 14556;
    num_errors = 0;
    num_checks = 0;
    curSeg     = seg_arith_pkg::SEG_DEFAULT;
    rst_n      = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (i < 4) curSeg = SEGS[i];
      if (i < 4) issue(PFX[i], seg_arith_pkg::OP_NONE, 5'h02, 3'h0, 8'h00, 16'h0000);
      if (i < 4) curSeg = SEGS[i];
      m = rnd_modrm(3'($random(seed)));
      issue(8'h03, seg_arith_pkg::OP_ADD, rc(m, 5'h03, 5'h0A), 3'h1, m, 16'h0000);
    end
    for (int i = 0; i < 16; i++) begin
      m = rnd_modrm(3'($random(seed)));
      issue(RM_BASE[i % 4] | 8'(i / 4), OPS[i % 4], rc(m, 5'h03, 5'h0A), 3'h1, m, 16'h0000);
    end
    for (int k = 1; k < 4; k++) begin
      for (int sw = 0; sw < 4; sw++) begin
        m = rnd_modrm(IMM_MID[k]);
        v = 16'($random(seed));
        v = (sw == 1) ? v : (sw == 3) ? {{8{v[7]}}, v[7:0]} : {8'h00, v[7:0]};
        issue(8'h80 | 8'(sw), OPS[k], rc(m, 5'h04, 5'h10), 3'h2, m, v);
      end
      for (int w = 0; w < 2; w++) begin
        v = 16'($random(seed));
        issue(ACC_BASE[k] | 8'(w), OPS[k], w ? 5'h04 : 5'h03, 3'h3, 8'h00, v);
      end
    end
    for (int w = 0; w < 2; w++) begin
      m = rnd_modrm(3'h3);
      issue(8'hF6 | 8'(w), seg_arith_pkg::OP_NEG, rc(m, 5'h03, 5'h0A), 3'h4, m, 16'h0000);
    end
    issue(8'h37, seg_arith_pkg::OP_AAA, 5'h08, 3'h0, 8'h00, 16'h0000);
    issue(8'h27, seg_arith_pkg::OP_DAA, 5'h04, 3'h0, 8'h00, 16'h0000);
    issue(8'h3F, seg_arith_pkg::OP_AAS, 5'h07, 3'h0, 8'h00, 16'h0000);
    issue(8'h2F, seg_arith_pkg::OP_DAS, 5'h04, 3'h0, 8'h00, 16'h0000);
    issue(8'h90, seg_arith_pkg::OP_NONE, 5'h00, 3'h0, 8'h00, 16'h0000);
    issue(8'h80, seg_arith_pkg::OP_NONE, 5'h00, 3'h4, 8'hC1, 16'h0000);
    issue(8'hF7, seg_arith_pkg::OP_NONE, 5'h00, 3'h4, 8'hE2, 16'h0000);
    issue(8'h2F, seg_arith_pkg::OP_DAS, 5'h04, 3'h0, 8'h00, 16'h0000);
    for (int i = 0; i < 5000 && (expQ.size() != 0 || i_prefetch_queue_model.pend.size() != 0); i++) begin
      @(posedge mclk);
    end
    if (expQ.size() != 0) check(16'(expQ.size()), 16'h0000, "items left undecoded");
    check(16'(i_prefetch_queue_model.pend.size()), 16'h0000, "bytes left unread");
    repeat (10) @(posedge mclk);
    finish_test();
  end
endmodule
